// ---- rtl/eeprom_access_defines.svh ----
/*
 holds the offsets, bit positions, timing counts and memory size of the
 eeprom access controller; assumes inclusion by bare name from rtl/.
*/
`ifndef EEPROM_ACCESS_DEFINES_SVH
`define EEPROM_ACCESS_DEFINES_SVH

// ==========================================================
// register indices on the cpu i/o port
`define EE_OFS_ADDR_LO     2'h0
`define EE_OFS_ADDR_HI     2'h1
`define EE_OFS_DATA        2'h2
`define EE_OFS_CONTROL     2'h3

// ==========================================================
// control register bit positions
`define EE_BIT_RIE         3
`define EE_BIT_MWE         2
`define EE_BIT_WE          1
`define EE_BIT_RE          0

// ==========================================================
// timing
`define EE_ARM_CYCLES      3'h4
`define EE_WRITE_STALL     3'h2
`define EE_READ_STALL      3'h4
`define EE_WRITE_OSC_TICKS 14'h2100
`define EE_OSC_HZ          100
`define EE_CLK_HZ          10000
`define EE_OSC_DIV         ((`EE_CLK_HZ) / (`EE_OSC_HZ))

`define EE_DEPTH           1024
`define EE_ADDR_W          10

`endif

// ---- rtl/eeprom_access_pkg.sv ----
/*
 holds the types of the eeprom access controller;
 assumes the defines header is compiled alongside.
*/
package eeprom_access_pkg;
   // one-hot states of the cpu-side host end
   typedef enum logic [3:0] {
      HOST_IDLE  = 4'h1,
      HOST_POLL  = 4'h2,
      HOST_ARM   = 4'h4,
      HOST_WAIT  = 4'h8
   } host_state_t;
endpackage : eeprom_access_pkg

// ---- rtl/eeprom_io_if.sv ----
/*
 i/o register port between cpu-side host and the eeprom controller;
 assumes both ends on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface eeprom_io_if;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       stall;
   logic       irq;
   logic       global_irq_enable;
   modport device (input addr, wdata, wr, rd, global_irq_enable,
                   output rdata, stall, irq);
   modport host   (output addr, wdata, wr, rd, global_irq_enable,
                   input rdata, stall, irq);
endinterface : eeprom_io_if
`default_nettype wire

// ---- rtl/eeprom_access_controller.sv ----
/*
 eeprom access controller: data, address and control registers, write arming,
 write timing, read path, cpu stall, ready interrupt. assumes a single clock
 at i_clk; the 100 Hz timing oscillator is derived by division of i_clk.
*/
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.svh"
module eeprom_access_controller
#(
   // clocks per oscillator tick; a bench may shorten it to keep runs brief
   parameter int OSC_DIV = `EE_OSC_DIV
)
(
   // clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_reset,
   // power state
   input  wire logic  i_power_down,
   // cpu i/o port
   eeprom_io_if.device io,
   // status
   output logic       o_write_busy,
   output logic       o_osc_running
);

   typedef struct packed {
      logic [9:0]  addr;
      logic [7:0]  data;
      logic        rie;
      logic        mwe;
      logic [2:0]  arm_cnt;
      logic        busy;
      logic [13:0] ticks;
      logic [6:0]  div;
      logic [2:0]  stall_cnt;
      logic [7:0]  rdata;
      logic        irq;
      logic        stall;
      logic        osc;
      logic        pd_hold;
   } state_t;

   // power-up state: reset keeps a running write, so busy needs a defined start
   state_t     s_reg = '0;
   state_t     s_next;
   logic [7:0] mem [0:`EE_DEPTH-1];
   logic       mem_we;

   function automatic logic [7:0] ctrl_view(input state_t s);
      ctrl_view = {4'h0, s.rie, s.mwe, s.busy, 1'b0};
   endfunction : ctrl_view

   // ==========================================================
   // next state
   always_comb
   begin
      s_next = s_reg;
      mem_we = 1'b0;
      // ==========================================================
      // arming window
      // a second arming write does not stretch the window
      if (s_reg.mwe)
      begin
         if (s_reg.arm_cnt == `EE_ARM_CYCLES - 3'h1)
         begin
            s_next.mwe     = 1'b0;
            s_next.arm_cnt = 3'h0;
         end
         else
            s_next.arm_cnt = s_reg.arm_cnt + 3'h1;
      end
      // ==========================================================
      // stall counter
      if (s_reg.stall_cnt != 3'h0)
         s_next.stall_cnt = s_reg.stall_cnt - 3'h1;
      // ==========================================================
      // write timer
      // write timer keeps running in power down and through reset
      if (s_reg.busy)
      begin
         if (s_reg.div == 7'(OSC_DIV - 1))
         begin
            s_next.div = 7'h0;
            if (s_reg.ticks == `EE_WRITE_OSC_TICKS - 14'h1)
            begin
               s_next.busy  = 1'b0;
               s_next.ticks = 14'h0;
               mem_we       = 1'b1;
            end
            else
               s_next.ticks = s_reg.ticks + 14'h1;
         end
         else
            s_next.div = s_reg.div + 7'h1;
      end
      // ==========================================================
      // register writes
      if (io.wr)
      begin
         case (io.addr)
            `EE_OFS_ADDR_LO:
               if (!s_reg.busy)
                  s_next.addr[7:0] = io.wdata;
            `EE_OFS_ADDR_HI:
               if (!s_reg.busy)
                  s_next.addr[9:8] = io.wdata[1:0];
            `EE_OFS_DATA:
               // stays writable while busy; the byte stored is taken at the end
               s_next.data = io.wdata;
            `EE_OFS_CONTROL:
            begin
               s_next.rie = io.wdata[`EE_BIT_RIE];
               if (io.wdata[`EE_BIT_MWE] && !io.wdata[`EE_BIT_WE] && !s_reg.mwe)
               begin
                  s_next.mwe     = 1'b1;
                  s_next.arm_cnt = 3'h0;
               end
               if (io.wdata[`EE_BIT_WE] && s_reg.mwe && !s_reg.busy)
               begin
                  s_next.busy      = 1'b1;
                  s_next.ticks     = 14'h0;
                  s_next.div       = 7'h0;
                  s_next.mwe       = 1'b0;
                  s_next.stall_cnt = `EE_WRITE_STALL;
               end
               else if (io.wdata[`EE_BIT_RE] && !s_reg.busy)
               begin
                  s_next.data      = mem[s_reg.addr];
                  s_next.stall_cnt = `EE_READ_STALL;
               end
            end
            default:
            begin
            end
         endcase
      end
      // ==========================================================
      // read data and outputs
      case (io.addr)
         `EE_OFS_ADDR_LO: s_next.rdata = s_reg.addr[7:0];
         `EE_OFS_ADDR_HI: s_next.rdata = {6'h0, s_reg.addr[9:8]};
         `EE_OFS_DATA:    s_next.rdata = s_reg.data;
         `EE_OFS_CONTROL: s_next.rdata = ctrl_view(s_reg);
         default:         s_next.rdata = 8'h00;
      endcase
      if (!io.rd)
         s_next.rdata = 8'h00;
      s_next.irq   = s_next.rie && io.global_irq_enable && !s_next.busy;
      s_next.stall = s_next.stall_cnt != 3'h0;
      // power down begun during a write keeps the oscillator on until it is left or a reset comes once the write is over
      s_next.pd_hold = i_power_down && (s_reg.busy || s_reg.pd_hold);
      s_next.osc     = !i_power_down || s_next.busy || s_next.pd_hold;
   end

   // ==========================================================
   // registers; reset leaves a running write alone
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         s_reg.rie       <= 1'b0;
         s_reg.mwe       <= 1'b0;
         s_reg.arm_cnt   <= 3'h0;
         s_reg.stall_cnt <= 3'h0;
         s_reg.rdata     <= 8'h00;
         s_reg.irq       <= 1'b0;
         s_reg.stall     <= 1'b0;
         s_reg.osc       <= 1'b1;
         s_reg.pd_hold   <= 1'b0;
         s_reg.addr      <= s_next.addr;
         s_reg.data      <= s_next.data;
         s_reg.busy      <= s_next.busy;
         s_reg.ticks     <= s_next.ticks;
         s_reg.div       <= s_next.div;
      end
      else
         s_reg <= s_next;
      if (mem_we)
         mem[s_reg.addr] <= s_reg.data;
   end

   assign io.rdata      = s_reg.rdata;
   assign io.stall      = s_reg.stall;
   assign io.irq        = s_reg.irq;
   assign o_write_busy  = s_reg.busy;
   assign o_osc_running = s_reg.osc;

endmodule : eeprom_access_controller
`default_nettype wire

// ---- rtl/eeprom_cpu_host.sv ----
/*
 cpu-side end: performs byte writes and reads of the eeprom through the
 controller's i/o port. assumes the controller answers reads one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.svh"
module eeprom_cpu_host
(
   // clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_reset,
   // user command
   input  wire logic  i_start,
   input  wire logic  i_is_write,
   input  wire logic [9:0] i_addr,
   input  wire logic [7:0] i_data,
   input  wire logic  i_self_program_enable,
   input  wire logic  i_irq_enable,
   // user answer
   output logic       o_done,
   output logic [7:0] o_rdata,
   output logic       o_busy,
   // link
   eeprom_io_if.host  io
);

   typedef struct packed {
      eeprom_access_pkg::host_state_t st;
      logic [2:0] step;
      logic       wr;
      logic [9:0] addr;
      logic [7:0] data;
      logic       io_wr;
      logic       io_rd;
      logic [1:0] io_addr;
      logic [7:0] io_wdata;
      logic       done;
      logic [7:0] rdata;
      logic       gie;
   } hstate_t;

   hstate_t h_reg;
   hstate_t h_next;

   always_comb
   begin
      h_next       = h_reg;
      h_next.io_wr = 1'b0;
      h_next.io_rd = 1'b0;
      h_next.done  = 1'b0;
      case (h_reg.st)
         eeprom_access_pkg::HOST_IDLE:
         begin
            h_next.gie = i_irq_enable;
            if (i_start)
            begin
               h_next.st   = eeprom_access_pkg::HOST_POLL;
               h_next.wr   = i_is_write;
               h_next.addr = i_addr;
               h_next.data = i_data;
               h_next.step = 3'h0;
               h_next.gie  = 1'b0;
            end
         end
         eeprom_access_pkg::HOST_POLL:
         begin
            // poll strobe and self programming flag before any access;
            // step 1 marks the cycle in which the last poll's data stand
            h_next.io_rd   = !h_reg.io_rd;
            h_next.io_addr = `EE_OFS_CONTROL;
            h_next.step    = {2'h0, h_reg.io_rd};
            if (h_reg.step[0] && !io.rdata[`EE_BIT_WE] && !i_self_program_enable)
            begin
               h_next.io_rd = 1'b0;
               h_next.st    = eeprom_access_pkg::HOST_ARM;
               h_next.step  = 3'h0;
            end
         end
         eeprom_access_pkg::HOST_ARM:
         begin
            h_next.step  = h_reg.step + 3'h1;
            h_next.io_wr = 1'b1;
            case (h_reg.step)
               3'h0: {h_next.io_addr, h_next.io_wdata} = {`EE_OFS_ADDR_LO, h_reg.addr[7:0]};
               3'h1: {h_next.io_addr, h_next.io_wdata} = {`EE_OFS_ADDR_HI, 6'h0, h_reg.addr[9:8]};
               3'h2: {h_next.io_addr, h_next.io_wdata} = {`EE_OFS_DATA, h_reg.data};
               3'h3:
               begin
                  // arm for a write, strobe a read; bit 3 carries the ready irq enable
                  h_next.io_addr  = `EE_OFS_CONTROL;
                  h_next.io_wdata = {4'h0, i_irq_enable, h_reg.wr, 1'b0, !h_reg.wr};
               end
               3'h4:
               begin
                  h_next.io_addr  = `EE_OFS_CONTROL;
                  h_next.io_wdata = {4'h0, i_irq_enable, 3'h2};
                  h_next.io_wr    = h_reg.wr;
               end
               default:
               begin
                  h_next.io_wr = 1'b0;
                  h_next.step  = 3'h0;
                  h_next.st    = eeprom_access_pkg::HOST_WAIT;
               end
            endcase
         end
         eeprom_access_pkg::HOST_WAIT:
         begin
            // the data register is read only once the stall is over
            case (h_reg.step)
               3'h0:
                  if (!io.stall)
                  begin
                     h_next.step    = 3'h1;
                     h_next.io_rd   = !h_reg.wr;
                     h_next.io_addr = `EE_OFS_DATA;
                  end
               3'h1:
                  h_next.step = 3'h2;
               default:
               begin
                  h_next.done  = 1'b1;
                  h_next.rdata = h_reg.wr ? 8'h00 : io.rdata;
                  h_next.gie   = i_irq_enable;
                  h_next.st    = eeprom_access_pkg::HOST_IDLE;
               end
            endcase
         end
         default:
            h_next.st = eeprom_access_pkg::HOST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         h_reg    <= '0;
         h_reg.st <= eeprom_access_pkg::HOST_IDLE;
      end
      else
         h_reg <= h_next;
   end

   assign io.addr              = h_reg.io_addr;
   assign io.wdata             = h_reg.io_wdata;
   assign io.wr                = h_reg.io_wr;
   assign io.rd                = h_reg.io_rd;
   assign io.global_irq_enable = h_reg.gie;
   assign o_done               = h_reg.done;
   assign o_rdata              = h_reg.rdata;
   assign o_busy               = h_reg.st != eeprom_access_pkg::HOST_IDLE;

endmodule : eeprom_cpu_host
`default_nettype wire

// ---- tb/eeprom_io_chk.sv ----
/*
 assertions on the eeprom i/o port.
 assumes it sits beside the interface, on its clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.svh"
module eeprom_io_chk
#(
   parameter int OSC_DIV = `EE_OSC_DIV
)
(
   // clock and reset
   input wire logic       i_clk,
   input wire logic       i_reset,
   // port
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       stall,
   input wire logic       irq,
   input wire logic       global_irq_enable
);
   localparam int LIM = `EE_WRITE_OSC_TICKS * OSC_DIV;
   // ==========
   // shadow state; write count ignores reset, as the write does
   logic [19:0] wcnt_reg = 20'h0;
   logic [2:0]  arm_reg;
   logic        rie_reg;
   wire logic   ctl_wr = wr && addr == `EE_OFS_CONTROL;
   wire logic   ctl_rd = rd && addr == `EE_OFS_CONTROL;
   always_ff @(posedge i_clk)
   begin
      if (ctl_wr && wdata[1] && arm_reg != 3'h0 && wcnt_reg == 20'h0)
         wcnt_reg <= 20'h1;
      else if (wcnt_reg != 20'h0)
         wcnt_reg <= (wcnt_reg == LIM[19:0]) ? 20'h0 : wcnt_reg + 20'h1;
      if (i_reset)
      begin
         arm_reg <= 3'h0;
         rie_reg <= 1'h0;
      end
      else
      begin
         // four-cycle arming window; only a taken strobe closes it early
         if (ctl_wr && wdata[2:1] == 2'h2 && arm_reg == 3'h0)
            arm_reg <= 3'h4;
         else if (ctl_wr && wdata[1] && wcnt_reg == 20'h0)
            arm_reg <= 3'h0;
         else if (arm_reg != 3'h0)
            arm_reg <= arm_reg - 3'h1;
         if (ctl_wr)
            rie_reg <= wdata[3];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // ==========
   // properties
   sequence arm_s;
      ctl_wr && wdata[2:1] == 2'h2;
   endsequence
   sequence strobe_s;
      ctl_wr && wdata[1];
   endsequence
   chk_write_stall: assert property (
      wcnt_reg == 20'h0 ##0 arm_s ##[1:4] strobe_s ##0 wcnt_reg == 20'h0
      |=> stall [*2] ##1 !stall)
      else $error("write stall wrong");
   chk_read_stall: assert property (
      wcnt_reg == 20'h0 && ctl_wr && wdata[1:0] == 2'h1 |=> stall [*4] ##1 !stall)
      else $error("read stall wrong");
   chk_busy_refuse: assert property (
      wcnt_reg > 20'h2 && ctl_wr && wdata[1:0] != 2'h0 |=> !stall)
      else $error("strobe taken while busy");
   chk_busy_one: assert property (
      ctl_rd && wcnt_reg > 20'h1 && wcnt_reg < LIM[19:0] |=> rdata[1:0] == 2'h2)
      else $error("busy not shown");
   chk_busy_zero: assert property (
      ctl_rd && wcnt_reg == 20'h0 |=> rdata[1:0] == 2'h0)
      else $error("busy past write time");
   chk_ctl_fields: assert property (
      ctl_rd |=> rdata[7:4] == 4'h0 && rdata[3] == $past(rie_reg))
      else $error("control fields wrong");
   chk_addr_high: assert property (
      rd && addr == `EE_OFS_ADDR_HI |=> rdata[7:2] == 6'h00)
      else $error("address high bits set");
   chk_irq_cause: assert property (
      irq == (rie_reg && $past(global_irq_enable) && wcnt_reg == 20'h0))
      else $error("irq level wrong");
endmodule : eeprom_io_chk
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 bench: host and controller joined by the i/o interface.
 assumes the design files and defines header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.svh"
module tb_top;
   // short oscillator divide keeps a full write inside the run budget
   localparam int DIV = 2;
   localparam int LIM = `EE_WRITE_OSC_TICKS * DIV;
   logic       i_clk = 1'h0;
   logic       i_reset = 1'h1;
   logic       start = 1'h0;
   logic       is_wr = 1'h0;
   logic       spm = 1'h0;
   logic       irq_en = 1'h0;
   logic       pd = 1'h0;
   logic [9:0] addr = 10'h000;
   logic [7:0] data = 8'h00;
   logic       done, busy, wbusy, osc;
   logic [7:0] rdata;
   int         errors = 0;
   int         checked = 0;
   int         bcnt = 0;
   eeprom_io_if io ();
   eeprom_access_controller #(.OSC_DIV(DIV)) eeprom_access_controller_i (.i_clk(i_clk),
      .i_reset(i_reset),
      .i_power_down(pd), .io(io.device), .o_write_busy(wbusy), .o_osc_running(osc));
   eeprom_cpu_host eeprom_cpu_host_i (.i_clk(i_clk), .i_reset(i_reset), .i_start(start),
      .i_is_write(is_wr), .i_addr(addr), .i_data(data), .i_self_program_enable(spm),
      .i_irq_enable(irq_en), .o_done(done), .o_rdata(rdata), .o_busy(busy), .io(io.host));
   eeprom_io_chk #(.OSC_DIV(DIV)) eeprom_io_chk_i (.i_clk(i_clk), .i_reset(i_reset),
      .addr(io.addr),
      .wdata(io.wdata), .wr(io.wr), .rd(io.rd), .rdata(io.rdata), .stall(io.stall),
      .irq(io.irq), .global_irq_enable(io.global_irq_enable));
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk)
      if (wbusy === 1'h1)
         bcnt <= bcnt + 1;
   // ==========
   // tasks
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check
   task automatic run_cmd(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      is_wr <= w;
      addr <= a;
      data <= d;
      start <= 1'h1;
      @(posedge i_clk);
      start <= 1'h0;
   endtask : run_cmd
   // polled at the falling edge so a one-cycle done pulse is seen
   task automatic wait_sig(input logic sel, input logic val, input int limit);
      int n;
      n = 0;
      do
      begin
         @(negedge i_clk);
         n++;
      end
      while ((sel ? wbusy : done) !== val && n < limit);
      check("wait", {31'h0, val}, {31'h0, sel ? wbusy : done});
   endtask : wait_sig
   task automatic report_and_stop;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // ==========
   // tests
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_reset <= 1'h0;
      spm <= 1'h1;
      irq_en <= 1'h1;
      run_cmd(1'h1, 10'h3FF, 8'hA5);
      repeat (50) @(negedge i_clk);
      check("write held", 1'h0, wbusy);
      check("host waiting", 1'h1, busy);
      @(posedge i_clk);
      spm <= 1'h0;
      wait_sig(1'h1, 1'h1, 300);
      $display("test self program hold done");
      @(posedge i_clk);
      pd <= 1'h1;
      repeat (100) @(negedge i_clk);
      check("osc running", 1'h1, osc);
      check("irq while busy", 1'h0, io.irq);
      @(posedge i_clk);
      i_reset <= 1'h1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'h0;
      @(negedge i_clk);
      check("busy after reset", 1'h1, wbusy);
      $display("test power down and reset done");
      run_cmd(1'h0, 10'h3FF, 8'h00);
      wait_sig(1'h0, 1'h1, LIM + 1000);
      check("read back", 8'hA5, rdata);
      check("write length", LIM, bcnt);
      check("busy cleared", 1'h0, wbusy);
      repeat (2) @(negedge i_clk);
      check("irq when ready", 1'h1, io.irq);
      check("osc held", 1'h1, osc);
      $display("test read after write done");
      report_and_stop();
   end
   initial
   begin
      repeat (LIM + 20000) @(posedge i_clk);
      errors++;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
